// ### hdl/bififo_pkg.sv
// Constants and pin bundles for the port B side of the bidirectional FIFO.
// Assumes every port pin, both port clocks included, is sampled on mclk.
package bififo_pkg;
  localparam int unsigned WORD_WIDTH     = 18;
  localparam int unsigned FIFO_DEPTH     = 512;
  localparam int unsigned OFFSET_WIDTH   = 9;
  localparam logic [8:0]  OFFSET_RESET   = 9'h008;
  localparam logic [2:0]  RSEL_FIFO      = 3'h0;
  localparam logic [2:0]  RSEL_BYPASS    = 3'h1;
  localparam logic [2:0]  RSEL_AB_AEMPTY = 3'h4;
  localparam logic [2:0]  RSEL_AB_AFULL  = 3'h5;
  localparam logic [2:0]  RSEL_BA_AEMPTY = 3'h6;
  localparam logic [2:0]  RSEL_BA_AFULL  = 3'h7;
  localparam int unsigned SYNC_STAGES    = 3;

  typedef enum logic [1:0] {
    BYP_IDLE   = 2'b00,
    BYP_ACTIVE = 2'b01,
    BYP_GRACE  = 2'b10
  } bypass_state_type;

  typedef struct packed {
    logic        clk;
    logic        select_n;
    logic        direction_select;
    logic        enable_n;
    logic [2:0]  resource_select;
    logic [17:0] data;
  } porta_pins_type;

  typedef struct packed {
    logic        clk;
    logic        direction_select;
    logic        enable_n;
    logic        output_enable_n;
    logic [17:0] data;
  } portb_pins_type;
endpackage

// ### hdl/bififo_portb.sv
// Two-direction FIFO core with port B read control, A-to-B bypass and flags.
// Assumes both port clocks are slow against mclk so each edge is seen once.
`timescale 1ns/10ps
module bififo_portb
  import bififo_pkg::*;
#(
  parameter int unsigned WIDTH = WORD_WIDTH,
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  // Clock, reset, enable
  input  wire logic               mclk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  // Port A pins
  input  wire porta_pins_type     porta_pins,
  output logic [WIDTH-1:0]        porta_data_out,
  output logic                    porta_data_oe,
  // Port B pins
  input  wire portb_pins_type     portb_pins,
  output logic [WIDTH-1:0]        portb_data_out,
  output logic                    portb_data_oe,
  output logic                    portb_bypass_indicator,
  // Flags, active low
  output logic                    ab_empty_flag_n,
  output logic                    ab_full_flag_n,
  output logic                    ab_almost_empty_n,
  output logic                    ab_almost_full_n,
  output logic                    ba_empty_flag_n,
  output logic                    ba_full_flag_n,
  output logic                    ba_almost_empty_n,
  output logic                    ba_almost_full_n
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned AWID = $bits(porta_pins_type);
  localparam int unsigned BWID = $bits(portb_pins_type);
  localparam logic [AW:0] DEPTH_W = (AW+1)'(DEPTH);

  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [AWID-1:0] a_s1_q, a_s2_q, a_s3_q, a_st_q;
  logic [BWID-1:0] b_s1_q, b_s2_q, b_s3_q, b_st_q;
  logic            a_clk_prev_q, b_clk_prev_q;
  porta_pins_type  a;
  portb_pins_type  b;
  logic            a_edge, b_edge;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_s1_q <= '0; a_s2_q <= '0; a_s3_q <= '0; a_st_q <= '0;
      b_s1_q <= '0; b_s2_q <= '0; b_s3_q <= '0; b_st_q <= '0;
      a_clk_prev_q <= 1'b0;
      b_clk_prev_q <= 1'b0;
    end
    else if (ce)
    begin
      a_s1_q <= porta_pins;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
      a_st_q <= (a_s2_q & ~(a_s2_q ^ a_s3_q)) | (a_st_q & (a_s2_q ^ a_s3_q));
      b_s1_q <= portb_pins;
      b_s2_q <= b_s1_q;
      b_s3_q <= b_s2_q;
      b_st_q <= (b_s2_q & ~(b_s2_q ^ b_s3_q)) | (b_st_q & (b_s2_q ^ b_s3_q));
      a_clk_prev_q <= a.clk;
      b_clk_prev_q <= b.clk;
    end
  end

  assign a = porta_pins_type'(a_st_q);
  assign b = portb_pins_type'(b_st_q);
  assign a_edge = ce & a.clk & ~a_clk_prev_q;
  assign b_edge = ce & b.clk & ~b_clk_prev_q;

  // Decoded port operations
  logic a_act, a_wr, a_rd, b_rd, b_wr, b_byp_sel;
  assign a_act = a_edge & ~a.select_n & ~a.enable_n;
  assign a_wr  = a_act & ~a.direction_select;
  assign a_rd  = a_act & a.direction_select;
  assign b_rd  = b_edge & b.direction_select & ~b.enable_n;
  assign b_wr  = b_edge & ~b.direction_select & ~b.enable_n;

  // Pointers and word counts
  logic [WIDTH-1:0] mem_ab [DEPTH];
  logic [WIDTH-1:0] mem_ba [DEPTH];
  logic [AW:0]      wptr_ab_q, rptr_ab_q, wptr_ba_q, rptr_ba_q;
  logic [AW:0]      cnt_ab, cnt_ba;
  assign cnt_ab = wptr_ab_q - rptr_ab_q;
  assign cnt_ba = wptr_ba_q - rptr_ba_q;

  // Flag offsets written from port A
  logic [OFFSET_WIDTH-1:0] off_ab_ae_q, off_ab_af_q, off_ba_ae_q, off_ba_af_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      off_ab_ae_q <= OFFSET_RESET;
      off_ab_af_q <= OFFSET_RESET;
      off_ba_ae_q <= OFFSET_RESET;
      off_ba_af_q <= OFFSET_RESET;
    end
    else if (a_wr)
    begin
      if (a.resource_select == RSEL_AB_AEMPTY)
        off_ab_ae_q <= a.data[OFFSET_WIDTH-1:0];
      else if (a.resource_select == RSEL_AB_AFULL)
        off_ab_af_q <= a.data[OFFSET_WIDTH-1:0];
      else if (a.resource_select == RSEL_BA_AEMPTY)
        off_ba_ae_q <= a.data[OFFSET_WIDTH-1:0];
      else if (a.resource_select == RSEL_BA_AFULL)
        off_ba_af_q <= a.data[OFFSET_WIDTH-1:0];
    end
  end

  // Bypass control
  bypass_state_type byp_q;
  logic [WIDTH-1:0] byp_word_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      byp_q <= BYP_IDLE;
    else
      case (byp_q)
        BYP_IDLE:
          if (a_wr && a.resource_select == RSEL_BYPASS)
            byp_q <= BYP_ACTIVE;
        BYP_ACTIVE:
          if (a_edge && a.select_n)
            byp_q <= BYP_GRACE;
        // One port B cycle, then forced
        BYP_GRACE:
          if (b_edge)
            byp_q <= BYP_IDLE;
        default:
          byp_q <= BYP_IDLE;
      endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      byp_word_q <= '0;
    else if (a_wr && a.resource_select == RSEL_BYPASS)
      byp_word_q <= a.data;
  end

  // Indicator rises as bypass state clears
  assign portb_bypass_indicator = (byp_q == BYP_IDLE);
  assign b_byp_sel = (a.resource_select == RSEL_BYPASS) && (byp_q != BYP_IDLE);

  // A-to-B write from port A; the memory has no reset so it maps to RAM
  always_ff @(posedge mclk)
  begin
    if (a_wr && a.resource_select == RSEL_FIFO && cnt_ab != DEPTH_W)
      mem_ab[wptr_ab_q[AW-1:0]] <= a.data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wptr_ab_q <= '0;
    else if (a_wr && a.resource_select == RSEL_FIFO && cnt_ab != DEPTH_W)
      wptr_ab_q <= wptr_ab_q + 1'b1;
  end

  // Port B output register and A-to-B read pointer
  logic [WIDTH-1:0] b_out_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      b_out_q   <= '0;
      rptr_ab_q <= '0;
    end
    // No read holds register and pointer
    else if (b_rd)
    begin
      if (b_byp_sel)
        b_out_q <= byp_word_q;
      else if (a.resource_select != RSEL_BYPASS && cnt_ab != '0)
      begin
        b_out_q   <= mem_ab[rptr_ab_q[AW-1:0]];
        rptr_ab_q <= rptr_ab_q + 1'b1;
      end
    end
  end

  // Port B write into B-to-A FIFO
  always_ff @(posedge mclk)
  begin
    if (b_wr && cnt_ba != DEPTH_W)
      mem_ba[wptr_ba_q[AW-1:0]] <= b.data;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wptr_ba_q <= '0;
    else if (b_wr && cnt_ba != DEPTH_W)
      wptr_ba_q <= wptr_ba_q + 1'b1;
  end

  // Port A read from B-to-A FIFO
  logic [WIDTH-1:0] a_out_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_out_q   <= '0;
      rptr_ba_q <= '0;
    end
    else if (a_rd && a.resource_select == RSEL_FIFO && cnt_ba != '0)
    begin
      a_out_q   <= mem_ba[rptr_ba_q[AW-1:0]];
      rptr_ba_q <= rptr_ba_q + 1'b1;
    end
  end

  // Bus drive enables, registered from the sampled pins
  logic a_oe_q, b_oe_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
    end
    else if (ce)
    begin
      a_oe_q <= ~a.select_n & a.direction_select;
      // Drive only while reading with output enabled
      b_oe_q <= b.direction_select & ~b.output_enable_n;
    end
  end

  // Flags: each is refreshed only on the edges of the clock it belongs to,
  // from counts taken before that edge's own access
  logic ab_ef_q, ab_ff_q, ab_ae_q, ab_af_q, ba_ef_q, ba_ff_q, ba_ae_q, ba_af_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ab_ef_q <= 1'b0; ab_ae_q <= 1'b0; ba_ff_q <= 1'b1; ba_af_q <= 1'b1;
    end
    else if (b_edge)
    begin
      ab_ef_q <= (cnt_ab != '0);
      ab_ae_q <= (cnt_ab > {1'b0, off_ab_ae_q});
      ba_ff_q <= (cnt_ba != DEPTH_W);
      ba_af_q <= (cnt_ba < DEPTH_W - {1'b0, off_ba_af_q});
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ba_ef_q <= 1'b0; ba_ae_q <= 1'b0; ab_ff_q <= 1'b1; ab_af_q <= 1'b1;
    end
    else if (a_edge)
    begin
      ab_ff_q <= (cnt_ab != DEPTH_W);
      ab_af_q <= (cnt_ab < DEPTH_W - {1'b0, off_ab_af_q});
      ba_ef_q <= (cnt_ba != '0);
      ba_ae_q <= (cnt_ba > {1'b0, off_ba_ae_q});
    end
  end

  assign porta_data_out    = a_out_q;
  assign porta_data_oe     = a_oe_q;
  assign portb_data_out    = b_out_q;
  assign portb_data_oe     = b_oe_q;
  assign ab_empty_flag_n   = ab_ef_q;
  assign ab_full_flag_n    = ab_ff_q;
  assign ab_almost_empty_n = ab_ae_q;
  assign ab_almost_full_n  = ab_af_q;
  assign ba_empty_flag_n   = ba_ef_q;
  assign ba_full_flag_n    = ba_ff_q;
  assign ba_almost_empty_n = ba_ae_q;
  assign ba_almost_full_n  = ba_af_q;

  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
    (b_edge && b.direction_select && b.enable_n) |=> $stable(b_out_q) && $stable(rptr_ab_q);
  endproperty
  a_hold: assert property (p_hold) else $error("port B register moved while disabled");

  property p_fifo_read;
    @(posedge mclk) disable iff (!rst_n)
    (b_rd && a.resource_select != RSEL_BYPASS && cnt_ab != '0)
      |=> rptr_ab_q == $past(rptr_ab_q) + 1'b1;
  endproperty
  a_fifo_read: assert property (p_fifo_read) else $error("read pointer did not advance");

  property p_byp_read;
    @(posedge mclk) disable iff (!rst_n)
    (b_rd && b_byp_sel) |=> b_out_q == $past(byp_word_q) && $stable(rptr_ab_q);
  endproperty
  a_byp_read: assert property (p_byp_read) else $error("bypass word not delivered");

  property p_exit;
    @(posedge mclk) disable iff (!rst_n)
    (byp_q == BYP_ACTIVE && a_edge && a.select_n) |=> byp_q == BYP_GRACE;
  endproperty
  a_exit: assert property (p_exit) else $error("bypass not left on select high");

  property p_force;
    @(posedge mclk) disable iff (!rst_n)
    (byp_q == BYP_GRACE && b_edge) |=> $rose(portb_bypass_indicator) && !b_byp_sel;
  endproperty
  a_force: assert property (p_force) else $error("port B not forced to FIFO mode");

  property p_empty;
    @(posedge mclk) disable iff (!rst_n)
    b_edge |=> ab_empty_flag_n == ($past(cnt_ab) != '0);
  endproperty
  a_empty: assert property (p_empty) else $error("empty flag disagrees with count");

  property p_afull;
    @(posedge mclk) disable iff (!rst_n)
    a_edge |=> !ab_almost_full_n == ($past(cnt_ab) >= DEPTH_W - {1'b0, $past(off_ab_af_q)});
  endproperty
  a_afull: assert property (p_afull) else $error("almost-full flag wrong");

  property p_aempty_hold;
    @(posedge mclk) disable iff (!rst_n)
    !b_edge |=> $stable(ab_almost_empty_n);
  endproperty
  a_aempty_hold: assert property (p_aempty_hold) else $error("almost-empty moved off B edge");

  property p_bwrite;
    @(posedge mclk) disable iff (!rst_n)
    (b_wr && cnt_ba != DEPTH_W) |=> wptr_ba_q == $past(wptr_ba_q) + 1'b1;
  endproperty
  a_bwrite: assert property (p_bwrite) else $error("port B write lost");

  property p_offset_reset;
    @(posedge mclk) $rose(rst_n) |-> off_ab_ae_q == OFFSET_RESET && off_ba_af_q == OFFSET_RESET;
  endproperty
  a_offset_reset: assert property (p_offset_reset) else $error("offsets not eight");
endmodule

// ### verif/port_hosts.sv
// Host processors on ports A and B of the bidirectional FIFO.
// Assumes mclk is the system clock; port clocks rest low between cycles.
`timescale 1ns/10ps
module port_hosts
  import bififo_pkg::*;
(
  // System clock
  input  wire logic mclk,
  // Pin bundles
  output porta_pins_type porta_pins,
  output portb_pins_type portb_pins
);
  // Each phase is longer than the design's sync delay, so the update lands before the fall
  localparam int HALF = 6;

  initial
  begin
    porta_pins = '0;
    porta_pins.select_n = 1'b1;
    portb_pins = '0;
    portb_pins.enable_n = 1'b1;
    portb_pins.output_enable_n = 1'b1;
  end

  // Controls stay put after the cycle; only the data bus changes, driven to the inverted word
  task automatic a_cycle(input logic sel_n, input logic dir, input logic [2:0] rsel,
                         input logic [17:0] d);
  begin
    @(negedge mclk);
    porta_pins.select_n = sel_n;
    porta_pins.direction_select = dir;
    porta_pins.enable_n = 1'b0;
    porta_pins.resource_select = rsel;
    porta_pins.data = d;
    repeat (HALF) @(negedge mclk);
    porta_pins.clk = 1'b1;
    repeat (HALF) @(negedge mclk);
    porta_pins.clk = 1'b0;
    porta_pins.data = ~d;
  end
  endtask

  task automatic b_cycle(input logic dir, input logic en_n, input logic oe_n,
                         input logic [17:0] d);
  begin
    @(negedge mclk);
    portb_pins.direction_select = dir;
    portb_pins.enable_n = en_n;
    portb_pins.output_enable_n = oe_n;
    portb_pins.data = d;
    repeat (HALF) @(negedge mclk);
    portb_pins.clk = 1'b1;
    repeat (HALF) @(negedge mclk);
    portb_pins.clk = 1'b0;
    portb_pins.data = ~d;
  end
  endtask
endmodule

// ### verif/tb_bififo_portb.sv
// Self-checking bench for the port B side of the bidirectional FIFO.
// Assumes port_hosts drives both pin bundles; depth is cut to 16 words.
`timescale 1ns/10ps
module tb_bififo_portb;
  import bififo_pkg::*;
  localparam int unsigned DEPTH_TB = 16;
  logic           mclk;
  logic           rst_n;
  porta_pins_type porta_pins;
  portb_pins_type portb_pins;
  logic [17:0]    a_out;
  logic [17:0]    b_out;
  logic           a_oe;
  logic           b_oe;
  logic           byp;
  wire [7:0]      fl;
  logic           ce;
  int             mismatches;
  int             total_checks;

  port_hosts u_hosts (.mclk(mclk), .porta_pins(porta_pins), .portb_pins(portb_pins));

  bififo_portb #(.DEPTH(DEPTH_TB)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce),
    .porta_pins(porta_pins), .porta_data_out(a_out), .porta_data_oe(a_oe),
    .portb_pins(portb_pins), .portb_data_out(b_out), .portb_data_oe(b_oe),
    .portb_bypass_indicator(byp),
    .ab_empty_flag_n(fl[0]), .ab_full_flag_n(fl[1]),
    .ab_almost_empty_n(fl[2]), .ab_almost_full_n(fl[3]),
    .ba_empty_flag_n(fl[4]), .ba_full_flag_n(fl[5]),
    .ba_almost_empty_n(fl[6]), .ba_almost_full_n(fl[7]));

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
  begin
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic check_bit(input logic got, input logic exp);
  begin
    check_word({17'h0, got}, {17'h0, exp});
  end
  endtask

  task automatic give_verdict;
  begin
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask

  task automatic test_reset;
  begin
    check_word({10'h000, fl}, 18'h000aa);
    check_bit(byp, 1'b1);
    check_bit(b_oe, 1'b0);
  end
  endtask

  // B writes into the B-to-A FIFO double as port B flag refresh edges
  task automatic test_fill;
  begin
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_FIFO, 18'h100);
    u_hosts.b_cycle(1'b0, 1'b0, 1'b1, 18'h2aa0);
    check_bit(fl[0], 1'b1);
    check_bit(fl[2], 1'b0);
    for (int i = 1; i < 9; i++)
      u_hosts.a_cycle(1'b0, 1'b0, RSEL_FIFO, 18'h100 + 18'(i));
    u_hosts.b_cycle(1'b0, 1'b0, 1'b1, 18'h2aa1);
    check_bit(fl[2], 1'b1);
    for (int i = 9; i < 16; i++)
      u_hosts.a_cycle(1'b0, 1'b0, RSEL_FIFO, 18'h100 + 18'(i));
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_BA_AEMPTY, 18'h008);
    check_bit(fl[1], 1'b0);
    check_bit(fl[3], 1'b0);
    // Write into a full FIFO must be dropped
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_FIFO, 18'h3ff);
  end
  endtask

  task automatic test_read;
  begin
    u_hosts.b_cycle(1'b1, 1'b1, 1'b0, 18'h0);
    check_word(b_out, 18'h0);
    check_bit(b_oe, 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      if (i == 8)
        u_hosts.a_cycle(1'b0, 1'b0, RSEL_BA_AEMPTY, 18'h008);
      u_hosts.b_cycle(1'b1, 1'b0, i[0], 18'h0);
      check_word(b_out, 18'h100 + 18'(i));
      check_bit(b_oe, ~i[0]);
    end
    u_hosts.b_cycle(1'b1, 1'b0, 1'b0, 18'h0);
    check_word(b_out, 18'h10f);
    check_bit(fl[0], 1'b0);
    check_bit(fl[2], 1'b0);
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_BA_AEMPTY, 18'h008);
    check_bit(fl[3], 1'b1);
    // Two words wait in the B-to-A FIFO: not empty, below both offsets
    check_word({14'h0000, fl[7:4]}, 18'h0000b);
    u_hosts.a_cycle(1'b0, 1'b1, RSEL_FIFO, 18'h0);
    check_word(a_out, 18'h2aa0);
    check_bit(a_oe, 1'b1);
  end
  endtask

  task automatic test_bypass;
  begin
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_BYPASS, 18'h1234b);
    check_bit(byp, 1'b0);
    u_hosts.b_cycle(1'b1, 1'b0, 1'b0, 18'h0);
    check_word(b_out, 18'h1234b);
    u_hosts.a_cycle(1'b1, 1'b0, RSEL_BYPASS, 18'h0);
    check_bit(byp, 1'b0);
    // Port B takes the pending word in its single grace cycle
    u_hosts.b_cycle(1'b1, 1'b0, 1'b0, 18'h0);
    check_word(b_out, 18'h1234b);
    check_bit(byp, 1'b1);
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_FIFO, 18'h0abc);
    u_hosts.b_cycle(1'b1, 1'b0, 1'b0, 18'h0);
    check_word(b_out, 18'h0abc);
  end
  endtask

  // Extreme offsets move both A-to-B thresholds away from their reset values
  task automatic test_offsets;
  begin
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_AB_AEMPTY, 18'h00000);
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_FIFO, 18'h00def);
    u_hosts.b_cycle(1'b0, 1'b0, 1'b1, 18'h02aa2);
    check_bit(fl[2], 1'b1);
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_AB_AFULL, 18'h0000f);
    u_hosts.a_cycle(1'b0, 1'b0, RSEL_BA_AFULL, 18'h0000f);
    check_bit(fl[3], 1'b0);
  end
  endtask

  // A low clock enable must hide a whole port B read
  task automatic test_freeze;
  begin
    ce = 1'b0;
    u_hosts.b_cycle(1'b1, 1'b0, 1'b0, 18'h00000);
    ce = 1'b1;
    check_word(b_out, 18'h00abc);
    u_hosts.b_cycle(1'b1, 1'b0, 1'b0, 18'h00000);
    check_word(b_out, 18'h00def);
    check_bit(fl[7], 1'b0);
  end
  endtask

  // Whole run is near 710 mclk; the limit leaves wide margin
  initial
  begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    give_verdict();
  end

  initial
  begin
    mismatches = 0;
    total_checks = 0;
    ce = 1'b1;
    rst_n = 1'b0;
    repeat (8) @(negedge mclk);
    test_reset();
    rst_n = 1'b1;
    test_fill();
    test_read();
    test_bypass();
    test_offsets();
    test_freeze();
    give_verdict();
  end
endmodule
